// file: inc/ogc_regs.svh
// Register offsets, field positions, reset values and timing figures for the output mixer block.
`ifndef OGC_REGS_SVH
`define OGC_REGS_SVH

// ==========================================================================
// Register offsets
`define OGC_ADDR_BIAS_POWER     7'h01
`define OGC_ADDR_STAGE_POWER    7'h03
`define OGC_ADDR_SLOW_CLOCK     7'h07
`define OGC_ADDR_SPK_MIX        7'h32
`define OGC_ADDR_SPK_GAIN       7'h36
`define OGC_ADDR_MONO_MIX       7'h38

// ==========================================================================
// Field positions
`define OGC_BIT_AMP_BIAS        3
`define OGC_BIT_MIDRAIL_BUF     2
`define OGC_BIT_MONO_DRV        7
`define OGC_BIT_NEG_SPK_DRV     6
`define OGC_BIT_POS_SPK_DRV     5
`define OGC_BIT_MONO_MIXER      3
`define OGC_BIT_SPK_MIXER       2
`define OGC_BIT_SLOW_TICK       0
`define OGC_BIT_SPK_AUX         5
`define OGC_BIT_SPK_BYPASS      1
`define OGC_BIT_SPK_CONV        0
`define OGC_BIT_SPK_CUT         8
`define OGC_BIT_SPK_ON_CROSS    7
`define OGC_BIT_SPK_SILENCE     6
`define OGC_BIT_MONO_CUT        7
`define OGC_BIT_MONO_SILENCE    6
`define OGC_BIT_MONO_AUX        2
`define OGC_BIT_MONO_BYPASS     1
`define OGC_BIT_MONO_CONV       0

// ==========================================================================
// Reset values and gain codes
`define OGC_RST_ZERO            9'h000
`define OGC_RST_SPK_GAIN        9'h079
`define OGC_GAIN_ZERO_DB        6'h39
`define OGC_GAIN_DB_OFFSET      7'sd57
`define OGC_CUT_NUM             9'sd81
`define OGC_CUT_SHIFT           8

// ==========================================================================
// Timing
`define OGC_CLK_HZ              25000000
`define OGC_ZC_TIMEOUT_HZ       31
`define OGC_SLOW_DIV_CYC        2097152

`endif

// file: inc/ogc_pkg.sv
// Types shared by the output mixer and gain control block.
package ogc_pkg;
    typedef logic [8:0] ogc_reg_t;
    typedef enum logic {OGC_ZC_IDLE, OGC_ZC_WAIT} ogc_zc_e;
endpackage : ogc_pkg

// file: design/ogc_output_mixer.sv
// Output mixer, speaker gain and output power control register bank.
`timescale 1ns/10ps
`include "ogc_regs.svh"

// Functional notes
// RULE_01 - Six-bit speaker gain, 1 dB steps: 63 is +6 dB, 57 is 0 dB, 0 is -57 dB.
// RULE_02 - With crossing bit set, gain changes only at a zero crossing; else at once.
// RULE_03 - Speaker silence resets to 1; while set both speaker outputs sit at mid-rail.
// RULE_04 - Speaker mix sums aux, bypass and converter, each selected by its bit.
// RULE_05 - Speaker bypass input is cut by 10 dB when bit 8 is set.
// RULE_06 - Mono mix sums aux, bypass and converter, each selected by its bit.
// RULE_07 - Mono bypass input is cut by 10 dB when bit 7 is set.
// RULE_08 - Mono silence bit puts mid-rail level on the mono output; reset unmuted.
// RULE_09 - Pending crossing gain is applied after a timeout when no crossing comes.
// RULE_10 - The crossing timeout runs only while the slow tick enable is set.
// RULE_11 - The same slow tick enable also clocks the jack-insert de-bounce tick.
// RULE_12 - Every enable is on at 1, off at 0; all stages off after reset.
// RULE_13 - Mono, negative and positive speaker drivers have enables at bits 7, 6, 5.
// RULE_14 - Mono and speaker mixers have own enables at bits 3 and 2.
// RULE_15 - Amplifier bias at bit 3 and mid-rail buffer at bit 2, both reset 0.
// RULE_16 - Software should not enable outputs while the mid-rail buffer is off.
// RULE_17 - Negative speaker output is the inverse of the positive one while both speaker drivers are on.
// RULE_18 - A crossing is a sign change between consecutive samples; gain waits for it.
module ogc_output_mixer
    import ogc_pkg::*;
#(
    parameter int W              = 16,
    parameter int ZC_TIMEOUT_CYC = `OGC_CLK_HZ / `OGC_ZC_TIMEOUT_HZ,
    parameter int SLOW_DIV_CYC   = `OGC_SLOW_DIV_CYC
) (
    // Clock and reset
    input  wire logic                clk_sys,
    input  wire logic                rst,
    // Register port
    input  wire logic                wr_en,
    input  wire logic [6:0]          wr_addr,
    input  wire logic [8:0]          wr_data,
    input  wire logic [6:0]          rd_addr,
    output logic      [8:0]          rd_data,
    // Audio samples
    input  wire logic                sample_valid,
    input  wire logic signed [W-1:0] dac_sample,
    input  wire logic signed [W-1:0] aux_sample,
    input  wire logic signed [W-1:0] bypass_sample,
    // Audio outputs, zero is the mid-rail level, and live speaker gain in dB and as code
    output logic signed [W+1:0]      speaker_out_pos,
    output logic signed [W+1:0]      speaker_out_neg,
    output logic signed [W+1:0]      mono_line_out,
    output logic signed [6:0]        speaker_gain_db,
    output logic [5:0]               speaker_gain_code,
    // Power enables and slow tick
    output logic                     amp_bias_on,
    output logic                     midrail_buffer_on,
    output logic                     mono_driver_on,
    output logic                     neg_speaker_driver_on,
    output logic                     pos_speaker_driver_on,
    output logic                     mono_mixer_on,
    output logic                     speaker_mixer_on,
    output logic                     debounce_tick
);

    // ======================================================================
    // Register file
    ogc_reg_t bias_r, bias_nxt, stage_r, stage_nxt, slow_r, slow_nxt;
    ogc_reg_t spkmix_r, spkmix_nxt, gain_r, gain_nxt, monomix_r, monomix_nxt;
    logic [8:0] rd_data_nxt;

    always_comb begin
        bias_nxt    = bias_r;
        stage_nxt   = stage_r;
        slow_nxt    = slow_r;
        spkmix_nxt  = spkmix_r;
        gain_nxt    = gain_r;
        monomix_nxt = monomix_r;
        if (wr_en) begin
            unique case (wr_addr)
                `OGC_ADDR_BIAS_POWER:  bias_nxt    = wr_data;
                `OGC_ADDR_STAGE_POWER: stage_nxt   = wr_data;
                `OGC_ADDR_SLOW_CLOCK:  slow_nxt    = wr_data;
                `OGC_ADDR_SPK_MIX:     spkmix_nxt  = wr_data;
                `OGC_ADDR_SPK_GAIN:    gain_nxt    = wr_data;
                `OGC_ADDR_MONO_MIX:    monomix_nxt = wr_data;
                default:               bias_nxt    = bias_r;
            endcase
        end
        unique case (rd_addr)
            `OGC_ADDR_BIAS_POWER:  rd_data_nxt = bias_r;
            `OGC_ADDR_STAGE_POWER: rd_data_nxt = stage_r;
            `OGC_ADDR_SLOW_CLOCK:  rd_data_nxt = slow_r;
            `OGC_ADDR_SPK_MIX:     rd_data_nxt = spkmix_r;
            `OGC_ADDR_SPK_GAIN:    rd_data_nxt = gain_r;
            `OGC_ADDR_MONO_MIX:    rd_data_nxt = monomix_r;
            default:               rd_data_nxt = `OGC_RST_ZERO;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            bias_r    <= `OGC_RST_ZERO;     // [RULE_12] [RULE_15]
            stage_r   <= `OGC_RST_ZERO;     // [RULE_12]
            slow_r    <= `OGC_RST_ZERO;
            spkmix_r  <= `OGC_RST_ZERO;
            gain_r    <= `OGC_RST_SPK_GAIN; // [RULE_03]
            monomix_r <= `OGC_RST_ZERO;     // [RULE_08]
            rd_data   <= `OGC_RST_ZERO;
        end else begin
            bias_r    <= bias_nxt;
            stage_r   <= stage_nxt;
            slow_r    <= slow_nxt;
            spkmix_r  <= spkmix_nxt;
            gain_r    <= gain_nxt;
            monomix_r <= monomix_nxt;
            rd_data   <= rd_data_nxt;
        end
    end

    assign amp_bias_on           = bias_r[`OGC_BIT_AMP_BIAS];      // [RULE_15]
    assign midrail_buffer_on     = bias_r[`OGC_BIT_MIDRAIL_BUF];   // [RULE_15]
    assign mono_driver_on        = stage_r[`OGC_BIT_MONO_DRV];     // [RULE_13]
    assign neg_speaker_driver_on = stage_r[`OGC_BIT_NEG_SPK_DRV];  // [RULE_13]
    assign pos_speaker_driver_on = stage_r[`OGC_BIT_POS_SPK_DRV];  // [RULE_13]
    assign mono_mixer_on         = stage_r[`OGC_BIT_MONO_MIXER];   // [RULE_14]
    assign speaker_mixer_on      = stage_r[`OGC_BIT_SPK_MIXER];    // [RULE_14]

    logic slow_tick_enable;
    assign slow_tick_enable = slow_r[`OGC_BIT_SLOW_TICK];

    // ======================================================================
    // Mixers
    // A fixed 81/256 gain stands in for -10 dB; it is within 0.05 dB.
    function automatic logic signed [W-1:0] ogc_cut(input logic signed [W-1:0] x);
        logic signed [W+8:0] p;
        p = (W+9)'(x) * (W+9)'(`OGC_CUT_NUM);
        return p[W+`OGC_CUT_SHIFT-1:`OGC_CUT_SHIFT];
    endfunction : ogc_cut

    logic signed [W-1:0] spk_byp, mono_byp;
    logic signed [W+1:0] spk_mix, mono_mix;

    always_comb begin
        spk_byp  = gain_r[`OGC_BIT_SPK_CUT] ? ogc_cut(bypass_sample) : bypass_sample;   // [RULE_05]
        mono_byp = monomix_r[`OGC_BIT_MONO_CUT] ? ogc_cut(bypass_sample) : bypass_sample; // [RULE_07]
        spk_mix  = '0;
        mono_mix = '0;
        if (spkmix_r[`OGC_BIT_SPK_AUX])     spk_mix = spk_mix + (W+2)'(aux_sample);  // [RULE_04]
        if (spkmix_r[`OGC_BIT_SPK_BYPASS])  spk_mix = spk_mix + (W+2)'(spk_byp);     // [RULE_04]
        if (spkmix_r[`OGC_BIT_SPK_CONV])    spk_mix = spk_mix + (W+2)'(dac_sample);  // [RULE_04]
        if (monomix_r[`OGC_BIT_MONO_AUX])   mono_mix = mono_mix + (W+2)'(aux_sample); // [RULE_06]
        if (monomix_r[`OGC_BIT_MONO_BYPASS]) mono_mix = mono_mix + (W+2)'(mono_byp);  // [RULE_06]
        if (monomix_r[`OGC_BIT_MONO_CONV])  mono_mix = mono_mix + (W+2)'(dac_sample); // [RULE_06]
    end

    // ======================================================================
    // Output stages
    logic signed [W+1:0] pos_nxt, neg_nxt, mono_nxt, spk_sig;
    logic                spk_live, mono_live;

    always_comb begin
        spk_live  = speaker_mixer_on && !gain_r[`OGC_BIT_SPK_SILENCE];            // [RULE_03]
        mono_live = mono_mixer_on && mono_driver_on
                    && !monomix_r[`OGC_BIT_MONO_SILENCE];                         // [RULE_08]
        spk_sig   = spk_live ? spk_mix : '0;
        pos_nxt   = speaker_out_pos;
        neg_nxt   = speaker_out_neg;
        mono_nxt  = mono_line_out;
        if (sample_valid) begin
            pos_nxt  = pos_speaker_driver_on ? spk_sig : '0;
            neg_nxt  = neg_speaker_driver_on ? -spk_sig : '0;                     // [RULE_17]
            mono_nxt = mono_live ? mono_mix : '0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            speaker_out_pos <= '0;
            speaker_out_neg <= '0;
            mono_line_out   <= '0;
        end else begin
            speaker_out_pos <= pos_nxt;
            speaker_out_neg <= neg_nxt;
            mono_line_out   <= mono_nxt;
        end
    end

    // ======================================================================
    // Slow tick for the de-bounce; its enable also gates the crossing timeout
    logic [23:0] slow_cnt_r, slow_cnt_nxt;
    logic        debounce_tick_nxt;

    always_comb begin
        slow_cnt_nxt      = '0;
        debounce_tick_nxt = 1'b0;
        if (slow_tick_enable) begin                                               // [RULE_11]
            if (slow_cnt_r == 24'(SLOW_DIV_CYC - 1)) begin
                debounce_tick_nxt = 1'b1;
            end else begin
                slow_cnt_nxt = slow_cnt_r + 24'h000001;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            slow_cnt_r    <= '0;
            debounce_tick <= 1'b0;
        end else begin
            slow_cnt_r    <= slow_cnt_nxt;
            debounce_tick <= debounce_tick_nxt;
        end
    end

    // ======================================================================
    // Speaker gain with crossing-synchronised update
    ogc_zc_e     zc_r, zc_nxt;
    logic [5:0]  live_r, live_nxt;
    logic [23:0] tmo_cnt_r, tmo_cnt_nxt;
    logic        prev_neg_r, prev_neg_nxt, crossing, timeout, gain_wr;

    always_comb begin
        gain_wr      = wr_en && (wr_addr == `OGC_ADDR_SPK_GAIN);
        prev_neg_nxt = sample_valid ? spk_mix[W+1] : prev_neg_r;
        crossing     = sample_valid && (spk_mix[W+1] != prev_neg_r);              // [RULE_18]
        timeout      = slow_tick_enable && (tmo_cnt_r == 24'(ZC_TIMEOUT_CYC - 1)); // [RULE_10]
        zc_nxt       = zc_r;
        live_nxt     = live_r;
        tmo_cnt_nxt  = '0;
        unique case (zc_r)
            OGC_ZC_IDLE: ;
            OGC_ZC_WAIT: begin
                if (crossing || timeout) begin                                    // [RULE_09]
                    live_nxt = gain_r[5:0];
                    zc_nxt   = OGC_ZC_IDLE;
                end else if (slow_tick_enable) begin
                    tmo_cnt_nxt = tmo_cnt_r + 24'h000001;
                end
            end
        endcase
        // A crossing write restarts the wait after a same-cycle apply of gain_r; a write without it overrides that apply.
        if (gain_wr) begin
            if (wr_data[`OGC_BIT_SPK_ON_CROSS]) begin                              // [RULE_02]
                zc_nxt      = OGC_ZC_WAIT;
                tmo_cnt_nxt = '0;
            end else begin
                live_nxt = wr_data[5:0];                                          // [RULE_02]
                zc_nxt   = OGC_ZC_IDLE;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            zc_r       <= OGC_ZC_IDLE;
            live_r     <= `OGC_GAIN_ZERO_DB;                                      // [RULE_01]
            tmo_cnt_r  <= '0;
            prev_neg_r <= 1'b0;
        end else begin
            zc_r       <= zc_nxt;
            live_r     <= live_nxt;
            tmo_cnt_r  <= tmo_cnt_nxt;
            prev_neg_r <= prev_neg_nxt;
        end
    end

    assign speaker_gain_code = live_r;
    assign speaker_gain_db   = $signed({1'b0, live_r}) - `OGC_GAIN_DB_OFFSET;     // [RULE_01]

    // ======================================================================
    // Assertions
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    sequence s_cross_write;
        gain_wr && wr_data[`OGC_BIT_SPK_ON_CROSS];
    endsequence

    sequence s_quiet_wait;
        !gain_wr && !crossing && !timeout;
    endsequence

    a_gain_db_map: assert property (speaker_gain_db == $signed({1'b0, live_r}) - 7'sd57) // [RULE_01]
        else $error("speaker gain in dB does not match the code");
    a_gain_immediate: assert property (gain_wr && !wr_data[7] |=> live_r == $past(wr_data[5:0])) // [RULE_02]
        else $error("gain did not apply at once with crossing off");
    a_gain_held: assert property (s_cross_write ##1 s_quiet_wait |=> $stable(live_r)) // [RULE_18]
        else $error("pending gain applied without crossing or timeout");
    a_gain_on_cross: assert property (zc_r == OGC_ZC_WAIT && crossing && !gain_wr
                                      |=> live_r == $past(gain_r[5:0]) && zc_r == OGC_ZC_IDLE) // [RULE_18]
        else $error("crossing did not apply pending gain");
    a_timeout_apply: assert property (zc_r == OGC_ZC_WAIT && timeout && !gain_wr
                                      |=> live_r == $past(gain_r[5:0])) // [RULE_09]
        else $error("timeout did not apply pending gain");
    a_timeout_gated: assert property (!slow_tick_enable |-> !timeout && !debounce_tick_nxt) // [RULE_10]
        else $error("timeout or tick ran without slow tick enable");
    a_spk_silence: assert property (gain_r[6] && sample_valid
                                    |=> speaker_out_pos == 0 && speaker_out_neg == 0) // [RULE_03]
        else $error("speaker output not at mid-rail while silenced");
    a_neg_inverse: assert property (pos_speaker_driver_on && neg_speaker_driver_on && sample_valid
                                    |=> speaker_out_neg == -speaker_out_pos) // [RULE_17]
        else $error("negative speaker output not inverse of positive");
    a_mono_silence: assert property (monomix_r[6] && sample_valid |=> mono_line_out == 0) // [RULE_08]
        else $error("mono output not at mid-rail while silenced");
    a_driver_off: assert property (!pos_speaker_driver_on && sample_valid // [RULE_12]
                                   |=> speaker_out_pos == 0)
        else $error("positive speaker output not at mid-rail while its driver is off");
    a_stage_enable: assert property (wr_en && wr_addr == 7'h03
                                     |=> mono_driver_on == $past(wr_data[7])
                                         && speaker_mixer_on == $past(wr_data[2])) // [RULE_13]
        else $error("stage power enable not taken from write");
    a_bias_enable: assert property (wr_en && wr_addr == 7'h01
                                    |=> amp_bias_on == $past(wr_data[3])
                                        && midrail_buffer_on == $past(wr_data[2])) // [RULE_15]
        else $error("bias power enable not taken from write");

endmodule : ogc_output_mixer

// file: testbench/ogc_output_mixer_tb.sv
// Self-checking testbench for the output mixer, gain and power register bank.
`timescale 1ns/10ps
`include "ogc_regs.svh"
module ogc_output_mixer_tb;
    import ogc_pkg::*;
    // ==========================================================================
    // Signals
    logic               clk_sys = 1'b0;
    logic               rst = 1'b1;
    logic               wr_en = 1'b0;
    logic [6:0]         wr_addr = 7'h00;
    logic [8:0]         wr_data = 9'h000;
    logic [6:0]         rd_addr = 7'h00;
    logic [8:0]         rd_data;
    logic               sample_valid = 1'b0;
    logic signed [15:0] dac_sample = 16'sh0000;
    logic signed [15:0] aux_sample = 16'sh0000;
    logic signed [15:0] bypass_sample = 16'sh0000;
    logic signed [17:0] speaker_out_pos, speaker_out_neg, mono_line_out;
    logic signed [6:0]  speaker_gain_db;
    logic [5:0]         speaker_gain_code;
    logic               amp_bias_on, midrail_buffer_on, mono_driver_on;
    logic               neg_speaker_driver_on, pos_speaker_driver_on;
    logic               mono_mixer_on, speaker_mixer_on, debounce_tick;
    int                 fail_count = 0;
    int                 tests_run = 0;
    int                 cyc = 0;
    localparam int      ZC = 20;
    always #20 clk_sys = ~clk_sys;
    // Short counts keep the timeout and slow tick within a brief run.
    ogc_output_mixer #(.W(16), .ZC_TIMEOUT_CYC(ZC), .SLOW_DIV_CYC(8)) u_ogc_output_mixer (
        .clk_sys(clk_sys), .rst(rst), .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data),
        .rd_addr(rd_addr), .rd_data(rd_data), .sample_valid(sample_valid),
        .dac_sample(dac_sample), .aux_sample(aux_sample), .bypass_sample(bypass_sample),
        .speaker_out_pos(speaker_out_pos), .speaker_out_neg(speaker_out_neg),
        .mono_line_out(mono_line_out), .speaker_gain_db(speaker_gain_db),
        .speaker_gain_code(speaker_gain_code), .amp_bias_on(amp_bias_on),
        .midrail_buffer_on(midrail_buffer_on), .mono_driver_on(mono_driver_on),
        .neg_speaker_driver_on(neg_speaker_driver_on),
        .pos_speaker_driver_on(pos_speaker_driver_on), .mono_mixer_on(mono_mixer_on),
        .speaker_mixer_on(speaker_mixer_on), .debounce_tick(debounce_tick));
    // ==========================================================================
    // Shared tasks
    task automatic give_verdict;
        if (fail_count == 0 && tests_run > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : give_verdict
    task automatic chk(input string name, input logic [17:0] seen, input logic [17:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk
    task automatic wr(input logic [6:0] a, input logic [8:0] d);
        @(negedge clk_sys);
        wr_en = 1'b1;
        wr_addr = a;
        wr_data = d;
        @(negedge clk_sys);
        wr_en = 1'b0;
    endtask : wr
    task automatic rd(input logic [6:0] a, output logic [8:0] v);
        @(negedge clk_sys);
        rd_addr = a;
        @(negedge clk_sys);
        v = rd_data;
    endtask : rd
    task automatic samp(input logic signed [15:0] d, a, b);
        @(negedge clk_sys);
        sample_valid = 1'b1;
        dac_sample = d;
        aux_sample = a;
        bypass_sample = b;
        @(negedge clk_sys);
        sample_valid = 1'b0;
    endtask : samp
    function automatic logic [17:0] ens();
        return {11'h000, amp_bias_on, midrail_buffer_on, mono_driver_on, neg_speaker_driver_on,
                pos_speaker_driver_on, mono_mixer_on, speaker_mixer_on};
    endfunction : ens
    // ==========================================================================
    // Scenarios
    task automatic t_reset;
        logic [6:0] addrs [7];
        logic [8:0] exps [7];
        logic [8:0] v;
        addrs = '{7'h01, 7'h03, 7'h07, 7'h32, 7'h36, 7'h38, 7'h05};
        exps = '{9'h000, 9'h000, 9'h000, 9'h000, 9'h079, 9'h000, 9'h000};
        for (int i = 0; i < 7; i++) begin
            rd(addrs[i], v);
            chk("reset reg", v, exps[i]);
        end
        chk("reset enables", ens(), 18'h00000);
        chk("reset code", speaker_gain_code, 18'h00039);
        chk("reset db", {11'h000, speaker_gain_db}, 18'h00000);
        chk("reset pos", speaker_out_pos, 18'h00000);
    endtask : t_reset
    task automatic t_enables;
        logic [8:0] v;
        wr(7'h01, 9'h004);
        wr(7'h03, 9'h0a8);
        chk("enables a", ens(), 18'h00036);
        wr(7'h01, 9'h008);
        wr(7'h03, 9'h044);
        chk("enables b", ens(), 18'h00049);
        wr(7'h02, 9'h1ff);
        rd(7'h02, v);
        chk("unmapped", v, 18'h00000);
        rd(7'h03, v);
        chk("stage readback", v, 18'h00044);
    endtask : t_enables
    task automatic t_gain_now;
        wr(7'h36, 9'h03f);
        chk("code max", speaker_gain_code, 18'h0003f);
        chk("db max", {11'h000, speaker_gain_db}, 18'h00006);
        wr(7'h36, 9'h000);
        chk("db min", {11'h000, speaker_gain_db}, 18'h00047);
    endtask : t_gain_now
    task automatic t_crossing;
        wr(7'h32, 9'h001);
        wr(7'h36, 9'h0b0);
        samp(16'sh0064, 16'sh0000, 16'sh0000);
        @(negedge clk_sys);
        chk("no crossing", speaker_gain_code, 18'h00000);
        samp(-16'sh0064, 16'sh0000, 16'sh0000);
        @(negedge clk_sys);
        chk("crossing", speaker_gain_code, 18'h00030);
    endtask : t_crossing
    task automatic t_timeout;
        int n;
        int ticks;
        wr(7'h36, 9'h0a0);
        repeat (2 * ZC) @(negedge clk_sys);
        chk("frozen", speaker_gain_code, 18'h00030);
        wr(7'h07, 9'h001);
        repeat (ZC / 2) @(negedge clk_sys);
        chk("not early", speaker_gain_code, 18'h00030);
        n = 0;
        while (speaker_gain_code !== 6'h20 && n < ZC) begin
            @(negedge clk_sys);
            n++;
        end
        chk("timeout", speaker_gain_code, 18'h00020);
        ticks = 0;
        repeat (32) begin
            @(negedge clk_sys);
            if (debounce_tick === 1'b1) ticks++;
        end
        chk("tick count", ticks[17:0], 18'h00004);
        wr(7'h07, 9'h000);
        ticks = 0;
        repeat (32) begin
            @(negedge clk_sys);
            if (debounce_tick === 1'b1) ticks++;
        end
        chk("tick off", ticks[17:0], 18'h00000);
    endtask : t_timeout
    task automatic t_audio;
        logic [8:0] ssel [4];
        logic [8:0] msel [4];
        logic signed [17:0] mix [4];
        ssel = '{9'h001, 9'h002, 9'h020, 9'h023};
        msel = '{9'h001, 9'h002, 9'h004, 9'h007};
        mix = '{18'sh00064, 18'sh00100, 18'sh000c8, 18'sh0022c};
        wr(7'h01, 9'h00c);
        wr(7'h03, 9'h0ec);
        wr(7'h36, 9'h039);
        for (int i = 0; i < 4; i++) begin
            wr(7'h32, ssel[i]);
            wr(7'h38, msel[i]);
            samp(16'sh0064, 16'sh00c8, 16'sh0100);
            chk("pos mix", speaker_out_pos, mix[i]);
            chk("neg mix", speaker_out_neg, -mix[i]);
            chk("mono mix", mono_line_out, mix[i]);
        end
        // Bypass of 256 cut to 81 keeps the sum small enough to read by hand.
        wr(7'h36, 9'h139);
        wr(7'h38, 9'h087);
        samp(16'sh0064, 16'sh00c8, 16'sh0100);
        chk("pos cut", speaker_out_pos, 18'sh0017d);
        chk("mono cut", mono_line_out, 18'sh0017d);
        wr(7'h36, 9'h079);
        samp(16'sh0064, 16'sh00c8, 16'sh0100);
        chk("pos silent", speaker_out_pos, 18'sh00000);
        chk("neg silent", speaker_out_neg, 18'sh00000);
        chk("mono live", mono_line_out, 18'sh0017d);
        wr(7'h38, 9'h0c7);
        samp(16'sh0064, 16'sh00c8, 16'sh0100);
        chk("mono silent", mono_line_out, 18'sh00000);
    endtask : t_audio
    // ==========================================================================
    // Watchdog and main sequence
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            fail_count++;
            give_verdict();
        end
    end
    initial begin
        repeat (10) @(negedge clk_sys);
        rst = 1'b0;
        t_reset();
        t_enables();
        t_gain_now();
        t_crossing();
        t_timeout();
        t_audio();
        give_verdict();
    end
endmodule : ogc_output_mixer_tb
